// file: tb/tcb_checker.sv
`include "tcb_defines.svh"
module tcb_checker (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        wrap_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ar_q;
    logic [7:0] ar_d;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    // Address of the read answer in flight.
    always_comb begin
        ar_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_q;
    end
    always_ff @(posedge clk) begin
        ar_q <= srst ? 8'h00 : ar_d;
    end
    ////////////////////////////////////////
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data beyond one byte");
    a_rresp_map: assert property (s_axi_rvalid |-> s_axi_rresp ==
        (({ar_q[7:2], 2'b00} > `TCB_OFS_FLAG) ? `TCB_RESP_SLVERR : `TCB_RESP_OKAY))
        else $error("bad rresp");
    a_wrap_clear: assert property ($fell(wrap_flag) |-> s_axi_bvalid)
        else $error("wrap flag lost without write");
    a_reset_idle: assert property (disable iff (1'b0) $fell(srst) |-> !s_axi_bvalid &&
        !s_axi_rvalid && !wrap_flag && s_axi_awready && s_axi_arready) else $error("reset state");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_wrap: cover property ($rose(wrap_flag));
endmodule : tcb_checker

bind tcb_timer tcb_checker tcb_checker_i (.*);

// file: tb/tcb_cpu_model.sv
module tcb_cpu_model (
    input  wire logic        clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    ////////////////////////////////////////
    // Callers never interleave accesses, so the shared latch stays intact.
    task automatic write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r,
                         output bit ok);
        int n;
        ok = 0;
        r = 2'b11;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100 && !ok; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~{24'h000000, d};
            end
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                ok = 1;
                s_axi_bready <= 1'b0;
            end
        end
    endtask : write
    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                        output bit ok);
        int n;
        ok = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100 && !ok; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                ok = 1;
                s_axi_rready <= 1'b0;
            end
        end
    endtask : read
endmodule : tcb_cpu_model

// file: tb/tcb_timer_tb_top.sv
`include "tcb_defines.svh"
module tcb_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        srst;
    logic        ext_tick_pin;
    logic        wrap_flag;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    int          n_fail;
    int          samples_checked;
    int          s;
    logic [15:0] v;
    int          divs [1:5] = '{1, 8, 64, 256, 1024};

    tcb_timer     tcb_timer_i (.*);
    tcb_cpu_model tcb_cpu_model_i (.*);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // Anything past the flag word is unmapped.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        bit         ok;
        tcb_cpu_model_i.write(a, d, r, ok);
        if (!ok) begin
            n_fail++;
            conclude();
        end
        check(r, (a > `TCB_OFS_FLAG) ? `TCB_RESP_SLVERR : `TCB_RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] b);
        logic [31:0] d;
        logic [1:0]  r;
        bit          ok;
        tcb_cpu_model_i.read(a, d, r, ok);
        if (!ok) begin
            n_fail++;
            conclude();
        end
        check(r, (a > `TCB_OFS_FLAG) ? `TCB_RESP_SLVERR : `TCB_RESP_OKAY);
        b = d[7:0];
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] b;
        rd(a, b);
        check(b, e);
    endtask : rdc
    task automatic wr16(input logic [7:0] a, input logic [15:0] w);
        wr(a + 8'h04, w[15:8]);
        wr(a, w[7:0]);
    endtask : wr16
    task automatic rd16(input logic [7:0] a, output logic [15:0] w);
        rd(a, w[7:0]);
        rd(a + 8'h04, w[15:8]);
    endtask : rd16
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            ext_tick_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_tick_pin <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask : pulses
    ////////////////////////////////////////
    initial begin
        srst = 1'b1;
        ext_tick_pin = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rdc(`TCB_OFS_CNT_HI, 8'h00);
        rdc(`TCB_OFS_CTL2, 8'h00);
        rdc(8'h30, 8'h00);
        wr(8'h30, 8'h5A);
        $display("test reset done");
        wr16(`TCB_OFS_CNT_LO, 16'h01FF);
        rdc(`TCB_OFS_CNT_HI, 8'h01);
        wr(`TCB_OFS_CNT_HI, 8'h77);
        rdc(`TCB_OFS_CNT_LO, 8'hFF);
        rdc(`TCB_OFS_CNT_HI, 8'h01);
        $display("test counter access done");
        wr(`TCB_OFS_MTA_HI, 8'h12);
        wr(`TCB_OFS_MTA_LO, 8'h34);
        wr(`TCB_OFS_MTB_LO, 8'h56);
        rdc(`TCB_OFS_MTB_HI, 8'h12);
        rdc(`TCB_OFS_MTB_LO, 8'h56);
        rdc(`TCB_OFS_CNT_LO, 8'hFF);
        rdc(`TCB_OFS_MTA_HI, 8'h12);
        rdc(`TCB_OFS_CNT_HI, 8'h01);
        rdc(`TCB_OFS_SNP_LO, 8'h00);
        rdc(`TCB_OFS_SNP_HI, 8'h00);
        $display("test shared latch done");
        for (s = 6; s <= 7; s++) begin
            wr16(`TCB_OFS_CNT_LO, 16'hFFFE);
            wr(`TCB_OFS_CTL2, 8'(s));
            pulses(3);
            wr(`TCB_OFS_CTL2, 8'h00);
            rd16(`TCB_OFS_CNT_LO, v);
            check(v, 16'h0001);
            check(wrap_flag, 1'b1);
            rdc(`TCB_OFS_FLAG, 8'h01);
            wr(`TCB_OFS_FLAG, 8'h01);
            check(wrap_flag, 1'b0);
        end
        wr(`TCB_OFS_CTL1, 8'h01);
        wr16(`TCB_OFS_CNT_LO, 16'h00FE);
        wr(`TCB_OFS_CTL2, 8'h07);
        pulses(3);
        wr(`TCB_OFS_CTL2, 8'h00);
        rd16(`TCB_OFS_CNT_LO, v);
        check(v, 16'h00FD);
        wr(`TCB_OFS_CTL1, 8'h00);
        $display("test external ticks done");
        for (s = 1; s <= 5; s++) begin
            wr16(`TCB_OFS_CNT_LO, 16'h0000);
            wr(`TCB_OFS_CTL2, 8'(s));
            repeat (2048) @(posedge clk);
            wr(`TCB_OFS_CTL2, 8'h00);
            rd16(`TCB_OFS_CNT_LO, v);
            check(v >= 2048 / divs[s] - 2 && v <= 2072 / divs[s] + 2, 1'b1);
        end
        $display("test internal ticks done");
        wr(`TCB_OFS_CTL2, 8'h01);
        repeat (10) @(posedge clk);
        wr16(`TCB_OFS_CNT_LO, 16'hABCD);
        wr(`TCB_OFS_CTL2, 8'h00);
        rd16(`TCB_OFS_CNT_LO, v);
        check(v >= 16'hABCD && v <= 16'hABE0, 1'b1);
        repeat (50) @(posedge clk);
        rd16(`TCB_OFS_CNT_LO, s[15:0]);
        check(s[15:0], v);
        $display("test write priority done");
        wr16(`TCB_OFS_CNT_LO, 16'h1234);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rdc(`TCB_OFS_CNT_HI, 8'h00);
        rdc(`TCB_OFS_CNT_LO, 8'h00);
        rdc(`TCB_OFS_MTA_HI, 8'h00);
        $display("test second reset done");
        conclude();
    end
endmodule : tcb_timer_tb_top

// file: verilog/tcb_cnt_if.sv
interface tcb_cnt_if;
    import tcb_pkg::*;
    logic      tick;
    tcb_mode_t mode;
    tcb_word_t match_a;
    tcb_word_t snapshot;
    logic      load;
    tcb_word_t load_val;
    tcb_word_t count;
    logic      at_top;
    logic      at_bottom;
    logic      wrap;
    modport ctrl (output tick, mode, match_a, snapshot, load, load_val,
                  input count, at_top, at_bottom, wrap);
    modport unit (input tick, mode, match_a, snapshot, load, load_val,
                  output count, at_top, at_bottom, wrap);
endinterface : tcb_cnt_if

// file: verilog/tcb_count_unit.sv
`include "tcb_defines.svh"
module tcb_count_unit import tcb_pkg::*; (
    input  wire logic clk,
    input  wire logic srst,
    tcb_cnt_if.unit   cif
);
    tcb_word_t cnt_q, cnt_d;
    tcb_dir_t  dir_q, dir_d;
    logic      wrap_q, wrap_d;
    tcb_word_t top;
    logic      dual, fast, cnt_en, clr;

    function automatic tcb_word_t top_of(input tcb_mode_t m,
                                         input tcb_word_t a, input tcb_word_t s);
        case (m)
            4'h1, 4'h5:             top_of = `TCB_TOP8;
            4'h2, 4'h6:             top_of = `TCB_TOP9;
            4'h3, 4'h7:             top_of = `TCB_TOP10;
            4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
            4'h8, 4'hA, 4'hC, 4'hE: top_of = s;
            default:                top_of = `TCB_MAX;
        endcase
    endfunction : top_of

    always_comb begin
        top    = top_of(cif.mode, cif.match_a, cif.snapshot);
        dual   = (cif.mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
        fast   = (cif.mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
        cnt_en = 1'b0;
        clr    = 1'b0;
        cnt_d  = cnt_q;
        dir_d  = dual ? dir_q : TCB_DIR_UP;
        wrap_d = 1'b0;
        if (cif.load) begin
            cnt_d = cif.load_val;
        end else if (cif.tick) begin
            cnt_en = 1'b1;
            if (dual) begin
                if (dir_q == TCB_DIR_UP && cnt_q >= top) begin
                    dir_d = TCB_DIR_DOWN;
                end else if (dir_q == TCB_DIR_DOWN && cnt_q == `TCB_BOTTOM) begin
                    dir_d  = TCB_DIR_UP;
                    wrap_d = 1'b1;
                end
            end else begin
                clr    = (cnt_q == top) && (cif.mode != 4'h0);
                wrap_d = fast ? (cnt_q == top) : (cnt_q == `TCB_MAX);
            end
            if (clr) begin
                cnt_d = `TCB_BOTTOM;
            end else if (dir_d == TCB_DIR_DOWN) begin
                cnt_d = cnt_q - 16'h0001;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q  <= `TCB_RST_WORD;
            dir_q  <= TCB_DIR_UP;
            wrap_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            dir_q  <= dir_d;
            wrap_q <= wrap_d;
        end
    end

    assign cif.count     = cnt_q;
    assign cif.at_top    = (cnt_q == top);
    assign cif.at_bottom = (cnt_q == `TCB_BOTTOM);
    assign cif.wrap      = wrap_q;
endmodule : tcb_count_unit

// file: verilog/tcb_defines.svh
`ifndef TCB_DEFINES_SVH
`define TCB_DEFINES_SVH
// Byte addresses of the register words.
`define TCB_OFS_CNT_LO  8'h00
`define TCB_OFS_CNT_HI  8'h04
`define TCB_OFS_MTA_LO  8'h08
`define TCB_OFS_MTA_HI  8'h0C
`define TCB_OFS_MTB_LO  8'h10
`define TCB_OFS_MTB_HI  8'h14
`define TCB_OFS_SNP_LO  8'h18
`define TCB_OFS_SNP_HI  8'h1C
`define TCB_OFS_CTL1    8'h20
`define TCB_OFS_CTL2    8'h24
`define TCB_OFS_FLAG    8'h28
// Field positions.
`define TCB_CTL1_MODE_LSB 0
`define TCB_CTL2_SRC_LSB  0
`define TCB_CTL2_MODE_LSB 3
`define TCB_FLAG_WRAP_BIT 0
// Reset values.
`define TCB_RST_BYTE 8'h00
`define TCB_RST_WORD 16'h0000
// Counter limits.
`define TCB_MAX    16'hFFFF
`define TCB_BOTTOM 16'h0000
`define TCB_TOP8   16'h00FF
`define TCB_TOP9   16'h01FF
`define TCB_TOP10  16'h03FF
// Prescaler taps: bits n down to 0 are all ones once every 2^(n+1) clocks.
`define TCB_PSC_W      10
`define TCB_TAP_DIV8    2
`define TCB_TAP_DIV64   5
`define TCB_TAP_DIV256  7
`define TCB_TAP_DIV1024 9
// Bus responses.
`define TCB_RESP_OKAY   2'b00
`define TCB_RESP_SLVERR 2'b10
`endif

// file: verilog/tcb_pkg.sv
package tcb_pkg;
    typedef enum logic [2:0] {
        TCB_SRC_STOP, TCB_SRC_CLK, TCB_SRC_DIV8, TCB_SRC_DIV64,
        TCB_SRC_DIV256, TCB_SRC_DIV1024, TCB_SRC_EXT_FALL, TCB_SRC_EXT_RISE
    } tcb_src_t;
    typedef enum logic {TCB_DIR_UP, TCB_DIR_DOWN} tcb_dir_t;
    typedef logic [3:0]  tcb_mode_t;
    typedef logic [15:0] tcb_word_t;

    // Modes whose top value is held in the snapshot register.
    function automatic logic tcb_snap_top(input tcb_mode_t m);
        return (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
    endfunction : tcb_snap_top
endpackage : tcb_pkg

// file: verilog/tcb_tick_sel.sv
`include "tcb_defines.svh"
module tcb_tick_sel import tcb_pkg::*; (
    input  wire logic     clk,
    input  wire logic     srst,
    input  wire tcb_src_t src,
    input  wire logic     ext_pin,
    output logic          tick
);
    logic [`TCB_PSC_W-1:0] psc_q, psc_d;
    logic [2:0]            ext_q, ext_d;
    logic                  tick_q, tick_d;

    always_comb begin
        psc_d = psc_q + `TCB_PSC_W'(1);
        ext_d = {ext_q[1:0], ext_pin};
        case (src)
            TCB_SRC_CLK:      tick_d = 1'b1;
            TCB_SRC_DIV8:     tick_d = &psc_q[`TCB_TAP_DIV8:0];
            TCB_SRC_DIV64:    tick_d = &psc_q[`TCB_TAP_DIV64:0];
            TCB_SRC_DIV256:   tick_d = &psc_q[`TCB_TAP_DIV256:0];
            TCB_SRC_DIV1024:  tick_d = &psc_q[`TCB_TAP_DIV1024:0];
            // Edges are taken between the second and third stage only.
            TCB_SRC_EXT_FALL: tick_d = ext_q[2] & ~ext_q[1];
            TCB_SRC_EXT_RISE: tick_d = ~ext_q[2] & ext_q[1];
            default:          tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            psc_q  <= '0;
            ext_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            psc_q  <= psc_d;
            ext_q  <= ext_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : tcb_tick_sel

// file: verilog/tcb_timer.sv
// Summary of operation
// - Sixteen-bit registers move as two byte transfers.
// - One shared high-byte holding latch for all.
// - Low-byte write loads latch plus byte together; snapshot only in modes 8, A, C, E.
// - Counter or snapshot low-byte read copies high half into latch.
// - Counter high location accesses the latch only.
// - Match high reads return own bits directly.
// - Latch keeps value; reuse for several writes.
// - Three-bit select picks internal or external tick.
// - Select zero gives no tick; counter holds.
// - Counter readable and writable at any time.
// - Software write beats count or clear.
// - Each tick clears, increments or decrements counter.
// - Four-bit mode split over two control registers.
// - Wrap flag set where the mode says.
// - Internal count, direction and clear signals.
// - Bottom at zero, top at sequence maximum.
// - Counter seen as upper and lower byte locations.
// - Maximum is all ones, bottom all zeros.
// - Top is fixed value, match A or snapshot.
`include "tcb_defines.svh"
module tcb_timer import tcb_pkg::*; (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_tick_pin,
    output logic             wrap_flag
);
    ////////////////////////////////////////////////////////////////////////
    // Bus channel state.
    logic        awready_q, awready_d;
    logic        wready_q,  wready_d;
    logic [7:0]  aw_addr_q, aw_addr_d;
    logic [7:0]  w_byte_q,  w_byte_d;
    logic        w_lane_q,  w_lane_d;
    logic        bvalid_q,  bvalid_d;
    logic [1:0]  bresp_q,   bresp_d;
    logic        arready_q, arready_d;
    logic        rvalid_q,  rvalid_d;
    logic [31:0] rdata_q,   rdata_d;
    logic [1:0]  rresp_q,   rresp_d;

    // Register state.
    logic [7:0] hold_q, hold_d;
    tcb_word_t  mta_q,  mta_d;
    tcb_word_t  mtb_q,  mtb_d;
    tcb_word_t  snp_q,  snp_d;
    logic [7:0] ctl1_q, ctl1_d;
    logic [7:0] ctl2_q, ctl2_d;
    logic       flag_q, flag_d;

    // Strobes of this cycle.
    logic       wr_go;
    logic       rd_go;
    logic [7:0] wb;
    logic       cnt_load;
    tcb_word_t  cnt_load_val;
    tcb_mode_t  mode;
    logic       tick;

    tcb_cnt_if cif ();

    function automatic logic mapped(input logic [7:0] a);
        return a inside {`TCB_OFS_CNT_LO, `TCB_OFS_CNT_HI, `TCB_OFS_MTA_LO,
                         `TCB_OFS_MTA_HI, `TCB_OFS_MTB_LO, `TCB_OFS_MTB_HI,
                         `TCB_OFS_SNP_LO, `TCB_OFS_SNP_HI, `TCB_OFS_CTL1,
                         `TCB_OFS_CTL2, `TCB_OFS_FLAG};
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    // Tick source and counter unit.
    assign mode = {ctl2_q[`TCB_CTL2_MODE_LSB +: 2],
                   ctl1_q[`TCB_CTL1_MODE_LSB +: 2]};

    tcb_tick_sel u_tick (
        .clk     (clk),
        .srst    (srst),
        .src     (tcb_src_t'(ctl2_q[`TCB_CTL2_SRC_LSB +: 3])),
        .ext_pin (ext_tick_pin),
        .tick    (tick)
    );

    assign cif.tick     = tick;
    assign cif.mode     = mode;
    assign cif.match_a  = mta_q;
    assign cif.snapshot = snp_q;
    assign cif.load     = cnt_load;
    assign cif.load_val = cnt_load_val;

    tcb_count_unit u_count (
        .clk  (clk),
        .srst (srst),
        .cif  (cif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write channel. Address and data are taken in either order; the
    // register update happens once both are held and no response waits.
    always_comb begin
        wr_go     = !awready_q && !wready_q && !bvalid_q;
        awready_d = awready_q;
        wready_d  = wready_q;
        aw_addr_d = aw_addr_q;
        w_byte_d  = w_byte_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            awready_d = 1'b0;
            aw_addr_d = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && wready_q) begin
            wready_d = 1'b0;
            w_byte_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (wr_go) begin
            bvalid_d  = 1'b1;
            bresp_d   = mapped(aw_addr_q) ? `TCB_RESP_OKAY : `TCB_RESP_SLVERR;
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_addr_q <= 8'h00;
            w_byte_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `TCB_RESP_OKAY;
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            aw_addr_q <= aw_addr_d;
            w_byte_q  <= w_byte_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel. One cycle from address to data; the latch copy made by
    // a low-byte read lands on the same edge as the returned byte.
    always_comb begin
        rd_go     = s_axi_arvalid && arready_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (rd_go) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = `TCB_RESP_OKAY;
            rdata_d   = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                `TCB_OFS_CNT_LO: rdata_d[7:0] = cif.count[7:0];
                `TCB_OFS_CNT_HI: rdata_d[7:0] = hold_q;
                `TCB_OFS_MTA_LO: rdata_d[7:0] = mta_q[7:0];
                `TCB_OFS_MTA_HI: rdata_d[7:0] = mta_q[15:8];
                `TCB_OFS_MTB_LO: rdata_d[7:0] = mtb_q[7:0];
                `TCB_OFS_MTB_HI: rdata_d[7:0] = mtb_q[15:8];
                `TCB_OFS_SNP_LO: rdata_d[7:0] = snp_q[7:0];
                `TCB_OFS_SNP_HI: rdata_d[7:0] = hold_q;
                `TCB_OFS_CTL1:   rdata_d[7:0] = ctl1_q;
                `TCB_OFS_CTL2:   rdata_d[7:0] = ctl2_q;
                `TCB_OFS_FLAG:   rdata_d[`TCB_FLAG_WRAP_BIT] = flag_q;
                default:         rresp_d = `TCB_RESP_SLVERR;
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `TCB_RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and the shared high-byte latch.
    always_comb begin
        wb           = w_byte_q;
        hold_d       = hold_q;
        mta_d        = mta_q;
        mtb_d        = mtb_q;
        snp_d        = snp_q;
        ctl1_d       = ctl1_q;
        ctl2_d       = ctl2_q;
        flag_d       = flag_q;
        cnt_load     = 1'b0;
        cnt_load_val = {hold_q, wb};
        // A counter or snapshot low-byte read refreshes the latch; a same-cycle high-byte
        // write below is applied later and so wins.
        if (rd_go) begin
            case ({s_axi_araddr[7:2], 2'b00})
                `TCB_OFS_CNT_LO: hold_d = cif.count[15:8];
                `TCB_OFS_SNP_LO: hold_d = snp_q[15:8];
                default:         hold_d = hold_d;
            endcase
        end
        if (wr_go && w_lane_q) begin
            case (aw_addr_q)
                `TCB_OFS_CNT_HI,
                `TCB_OFS_MTA_HI,
                `TCB_OFS_MTB_HI,
                `TCB_OFS_SNP_HI: hold_d = wb;
                `TCB_OFS_CNT_LO: cnt_load = 1'b1;
                `TCB_OFS_MTA_LO: mta_d = {hold_q, wb};
                `TCB_OFS_MTB_LO: mtb_d = {hold_q, wb};
                `TCB_OFS_SNP_LO: begin
                    // Snapshot is writable only while it defines the top.
                    if (tcb_snap_top(mode)) begin
                        snp_d = {hold_q, wb};
                    end
                end
                `TCB_OFS_CTL1:   ctl1_d = {6'h00, wb[1:0]};
                `TCB_OFS_CTL2:   ctl2_d = {3'h0, wb[4:0]};
                `TCB_OFS_FLAG: begin
                    if (wb[`TCB_FLAG_WRAP_BIT]) begin
                        flag_d = 1'b0;
                    end
                end
                default:         hold_d = hold_d;
            endcase
        end
        // Setting after the clear means a wrap in the clearing cycle stays.
        if (cif.wrap) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hold_q <= `TCB_RST_BYTE;
            mta_q  <= `TCB_RST_WORD;
            mtb_q  <= `TCB_RST_WORD;
            snp_q  <= `TCB_RST_WORD;
            ctl1_q <= `TCB_RST_BYTE;
            ctl2_q <= `TCB_RST_BYTE;
            flag_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            mta_q  <= mta_d;
            mtb_q  <= mtb_d;
            snp_q  <= snp_d;
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            flag_q <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wrap_flag     = flag_q;
endmodule : tcb_timer
